// File: hdl/tep_consts.vh
// constants for the trim eeprom programming block
// assumes a 50 MHz system clock and a 32-bit apb register bus
`ifndef TEP_CONSTS_VH
`define TEP_CONSTS_VH

// apb byte offsets
`define TEP_ADDR_CTRL        8'h00
`define TEP_ADDR_STATUS      8'h04
`define TEP_ADDR_SHIFT       8'h08
`define TEP_ADDR_MAP_BASE    8'h40

// ctrl fields
`define TEP_CTRL_HOLD        0
`define TEP_CTRL_FRAME_CLR   1

// status fields
`define TEP_ST_FRAME_FULL    0
`define TEP_ST_FIFO_EMPTY    1
`define TEP_ST_FIFO_FULL     2
`define TEP_ST_OVERFLOW      3
`define TEP_ST_BAD_INDEX     4
`define TEP_ST_BAD_FILTER    5
`define TEP_ST_NO_SUPPLY     6
`define TEP_ST_SHORT_FRAME   7
`define TEP_ST_COUNT_LSB     8

// frame layout, first bit in ends in bit 0
`define TEP_FRAME_BITS       5'h10
`define TEP_FR_TAIL          0
`define TEP_FR_IDX_LSB       1
`define TEP_FR_IDX_MSB       4
`define TEP_FR_DATA_LSB      5
`define TEP_FR_DATA_MSB      14
`define TEP_FR_CLEAR_N       15

// eeprom map
`define TEP_MAP_WORDS        4'ha
`define TEP_LOC_CAP_LO       4'h4
`define TEP_LOC_CAP_HI       4'h5
`define TEP_LOC_FEEDBACK     4'h6
`define TEP_LOC_FILTER       4'h7
`define TEP_LOC_GAIN         4'h8
`define TEP_LOC_BIAS         4'h9

// decode constants
`define TEP_CAP_STEP_FF      14'h013
`define TEP_DC_NOMINAL       6'h10
`define TEP_GAIN_NOMINAL     9'h080
`define TEP_FILTER_CODES     4'h9

`endif

// File: hdl/tep_fifo.v
// synchronous fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ns
module tep_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             full,
  output wire             empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  assign full      = (count_q == DEPTH[AW:0]);
  assign empty     = (count_q == {(AW+1){1'b0}});
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_q];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // tep_fifo

// File: hdl/tep_sync.v
// two-flop synchroniser for a group of independent levels
// assumes each bit is a slow level from outside the clock domain
`timescale 1ns/1ns
module tep_sync #(
  parameter W = 4
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // tep_sync

// File: hdl/tep_top.v
// serial eeprom programming port, trim map and trim field decode
// assumes apb master on CLOCK; programmer pins are asynchronous and slow
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "tep_consts.vh"
module tep_top #(
  parameter APPLY_DIV   = 16,
  parameter ERASED_WORD = 10'h000
) (
  input  wire        CLOCK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg         PREADY,
  output reg  [31:0] PRDATA,
  output reg         PSLVERR,
  input  wire        PROG_SUPPLY_PIN,
  input  wire        SERIAL_IN_PIN,
  input  wire        SERIAL_STROBE_PIN,
  input  wire        COMMIT_PIN,
  output reg  [8:0]  BALANCE_CAP_CODE,
  output reg  [13:0] BALANCE_CAP_FF,
  output reg  [5:0]  TRIM_CAP_CODE,
  output reg  [10:0] TRIM_CAP_FF,
  output reg  [9:0]  FEEDBACK_CAP_CODE,
  output reg  [3:0]  FILTER_CORNER_CODE,
  output reg  [8:0]  FILTER_SEL,
  output reg         OUTPUT_BASE_SEL,
  output reg  [4:0]  DC_SHIFT_TRIM,
  output reg  [5:0]  DC_SHIFT_STEPS,
  output reg  [7:0]  GAIN_FINE_TRIM,
  output reg  [8:0]  GAIN_FINE_STEPS,
  output reg         AMP_RANGE_SEL,
  output reg  [3:0]  REF_VOLT_TRIM,
  output reg  [2:0]  BIAS_CURRENT_TRIM,
  output reg  [2:0]  OSC_TRIM
);
  // ==========================================================
  // pin synchronisers
  wire [3:0] pins_s;
  wire       data_s;
  wire       strobe_s;
  wire       commit_s;
  wire       supply_s;
  reg        strobe_prev_q;
  reg        commit_prev_q;

  tep_sync #(.W(4)) u_sync (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .async_in ({PROG_SUPPLY_PIN, COMMIT_PIN, SERIAL_STROBE_PIN, SERIAL_IN_PIN}),
    .sync_out (pins_s)
  );
  assign data_s   = pins_s[0];
  assign strobe_s = pins_s[1];
  assign commit_s = pins_s[2];
  assign supply_s = pins_s[3];

  wire strobe_rise = strobe_s && !strobe_prev_q;
  wire commit_rise = commit_s && !commit_prev_q;

  // ==========================================================
  // frame shifter
  reg  [15:0] shift_q;
  reg  [4:0]  count_q;
  reg         hold_q;
  wire        frame_full = (count_q == `TEP_FRAME_BITS);
  wire        apb_wr;
  wire        frame_clr;
  wire        fifo_in_ready;
  wire        fifo_push = commit_rise && frame_full && supply_s;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      strobe_prev_q <= 1'b0;
      commit_prev_q <= 1'b0;
      shift_q       <= 16'h0000;
      count_q       <= 5'h00;
    end else begin
      strobe_prev_q <= strobe_s;
      commit_prev_q <= commit_s;
      if (strobe_rise) begin
        shift_q <= {data_s, shift_q[15:1]};
      end
      if (commit_rise || frame_clr) begin
        count_q <= 5'h00;
      end else if (strobe_rise && !frame_full) begin
        count_q <= count_q + 5'h01;
      end
    end
  end

  // ==========================================================
  // committed frame queue; drain may be held so it fills
  wire        fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire        fifo_full;
  wire        fifo_empty;
  reg         tick_q;
  reg  [15:0] div_q;
  wire        drain = tick_q && !hold_q;

  tep_fifo #(.WIDTH(16), .DEPTH(16), .AW(4)) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_q),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  // apply rate: one frame per enable pulse, models cell write time
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == APPLY_DIV[15:0] - 16'h0001) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // eeprom map and sticky flags
  reg  [9:0] map_q [0:15];
  reg        overflow_q;
  reg        bad_index_q;
  reg        no_supply_q;
  reg        short_frame_q;
  wire       pop = fifo_out_valid && drain;
  wire [3:0] fr_idx = fifo_out_data[`TEP_FR_IDX_MSB:`TEP_FR_IDX_LSB];
  wire       st_clr = apb_wr && (PADDR == `TEP_ADDR_STATUS);
  integer    i;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (i = 0; i < 16; i = i + 1) begin
        map_q[i] <= 10'h000;
      end
    end else if (pop) begin
      if (!fifo_out_data[`TEP_FR_CLEAR_N]) begin
        for (i = 0; i < 16; i = i + 1) begin
          map_q[i] <= ERASED_WORD;
        end
      end else if (fr_idx < `TEP_MAP_WORDS) begin
        map_q[fr_idx] <= fifo_out_data[`TEP_FR_DATA_MSB:`TEP_FR_DATA_LSB];
      end
    end
  end

  // set wins over a software clear in the same cycle
  wire set_ovf   = fifo_push && !fifo_in_ready;
  wire set_badix = pop && fifo_out_data[`TEP_FR_CLEAR_N] && !(fr_idx < `TEP_MAP_WORDS);
  wire set_nosup = commit_rise && frame_full && !supply_s;
  wire set_short = commit_rise && !frame_full;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      overflow_q    <= 1'b0;
      bad_index_q   <= 1'b0;
      no_supply_q   <= 1'b0;
      short_frame_q <= 1'b0;
    end else begin
      overflow_q    <= set_ovf   || (overflow_q    && !(st_clr && PWDATA[`TEP_ST_OVERFLOW]));
      bad_index_q   <= set_badix || (bad_index_q   && !(st_clr && PWDATA[`TEP_ST_BAD_INDEX]));
      no_supply_q   <= set_nosup || (no_supply_q   && !(st_clr && PWDATA[`TEP_ST_NO_SUPPLY]));
      short_frame_q <= set_short || (short_frame_q && !(st_clr && PWDATA[`TEP_ST_SHORT_FRAME]));
    end
  end

  // ==========================================================
  // field decode from the map
  wire [9:0]  w4 = map_q[`TEP_LOC_CAP_LO];
  wire [9:0]  w5 = map_q[`TEP_LOC_CAP_HI];
  wire [9:0]  w6 = map_q[`TEP_LOC_FEEDBACK];
  wire [9:0]  w7 = map_q[`TEP_LOC_FILTER];
  wire [9:0]  w8 = map_q[`TEP_LOC_GAIN];
  wire [9:0]  w9 = map_q[`TEP_LOC_BIAS];
  // only locations 4 to 9 used
  wire [8:0]  bal_d  = {w5[6:0], w4[9], w4[8]};
  wire [5:0]  trim_d = {w4[2], w4[3], w4[4], w4[5], w4[6], w4[7]};
  wire [3:0]  filt_d = {w7[4], w7[3], w7[2], w7[1]};
  wire [4:0]  dc_d   = {w7[6], w7[7], w7[8], w7[9], w8[0]};
  wire [7:0]  gain_d = {w8[1], w8[2], w8[3], w8[4], w8[5], w8[6], w8[7], w8[8]};
  wire [13:0] bal_ff  = {5'h00, bal_d} * `TEP_CAP_STEP_FF;
  wire [13:0] trim_ff = {8'h00, trim_d} * `TEP_CAP_STEP_FF;
  reg  [8:0]  filt_sel;
  wire        bad_filter = !(filt_d < `TEP_FILTER_CODES);

  always @* begin
    filt_sel = 9'h000;
    case (filt_d)
      4'h0:    filt_sel = 9'h001;
      4'h1:    filt_sel = 9'h002;
      4'h2:    filt_sel = 9'h004;
      4'h3:    filt_sel = 9'h008;
      4'h4:    filt_sel = 9'h010;
      4'h5:    filt_sel = 9'h020;
      4'h6:    filt_sel = 9'h040;
      4'h7:    filt_sel = 9'h080;
      4'h8:    filt_sel = 9'h100;
      default: filt_sel = 9'h000;
    endcase
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BALANCE_CAP_CODE   <= 9'h000;
      BALANCE_CAP_FF     <= 14'h0000;
      TRIM_CAP_CODE      <= 6'h00;
      TRIM_CAP_FF        <= 11'h000;
      FEEDBACK_CAP_CODE  <= 10'h000;
      FILTER_CORNER_CODE <= 4'h0;
      FILTER_SEL         <= 9'h001;
      OUTPUT_BASE_SEL    <= 1'b0;
      DC_SHIFT_TRIM      <= 5'h00;
      DC_SHIFT_STEPS     <= 6'h30;
      GAIN_FINE_TRIM     <= 8'h00;
      GAIN_FINE_STEPS    <= 9'h180;
      AMP_RANGE_SEL      <= 1'b0;
      REF_VOLT_TRIM      <= 4'h0;
      BIAS_CURRENT_TRIM  <= 3'h0;
      OSC_TRIM           <= 3'h0;
    end else begin
      BALANCE_CAP_CODE   <= bal_d;
      BALANCE_CAP_FF     <= bal_ff;
      TRIM_CAP_CODE      <= trim_d;
      TRIM_CAP_FF        <= trim_ff[10:0];
      FEEDBACK_CAP_CODE  <= {w6[6:0], w5[9], w5[8], w5[7]};
      FILTER_CORNER_CODE <= filt_d;
      FILTER_SEL         <= filt_sel;
      OUTPUT_BASE_SEL    <= w7[5];
      DC_SHIFT_TRIM      <= dc_d;
      DC_SHIFT_STEPS     <= {1'b0, dc_d} - `TEP_DC_NOMINAL;
      GAIN_FINE_TRIM     <= gain_d;
      GAIN_FINE_STEPS    <= {1'b0, gain_d} - `TEP_GAIN_NOMINAL;
      AMP_RANGE_SEL      <= w6[8];
      REF_VOLT_TRIM      <= w9[6:3];
      BIAS_CURRENT_TRIM  <= w9[9:7];
      OSC_TRIM           <= {w9[0], w9[1], w9[2]};
    end
  end

  // ==========================================================
  // apb slave: decode in setup, answer in the first access cycle
  reg  [31:0] rd_d;
  reg         err_d;
  reg         frame_clr_q;
  wire        map_hit = (PADDR[7:6] == 2'b01) && (PADDR[1:0] == 2'b00) && (PADDR[5:2] < `TEP_MAP_WORDS);
  wire        setup   = PSEL && !PENABLE && !PREADY;
  assign apb_wr    = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign frame_clr = frame_clr_q;

  always @* begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (PADDR)
      `TEP_ADDR_CTRL:   rd_d = {31'h00000000, hold_q};
      `TEP_ADDR_STATUS: rd_d = {19'h00000, count_q, short_frame_q, no_supply_q, bad_filter,
                                bad_index_q, overflow_q, fifo_full, fifo_empty, frame_full};
      `TEP_ADDR_SHIFT:  rd_d = {16'h0000, shift_q};
      default: begin
        if (map_hit) begin
          rd_d = {22'h000000, map_q[PADDR[5:2]]};
        end else begin
          err_d = 1'b1;
        end
      end
    endcase
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY      <= 1'b0;
      PRDATA      <= 32'h00000000;
      PSLVERR     <= 1'b0;
      hold_q      <= 1'b0;
      frame_clr_q <= 1'b0;
    end else begin
      PREADY      <= setup;
      frame_clr_q <= apb_wr && (PADDR == `TEP_ADDR_CTRL) && PWDATA[`TEP_CTRL_FRAME_CLR];
      if (setup) begin
        PRDATA  <= PWRITE ? 32'h00000000 : rd_d;
        PSLVERR <= err_d;
      end else if (PREADY) begin
        PSLVERR <= 1'b0;
      end
      if (apb_wr && (PADDR == `TEP_ADDR_CTRL)) begin
        hold_q <= PWDATA[`TEP_CTRL_HOLD];
      end
    end
  end
endmodule // tep_top

// File: tb/tep_prog_model.sv
// programmer model: supply, serial data, strobe and commit pins
// assumes a 20 ns clock; one bit per 160 ns link period
`timescale 1ns/1ns
module tep_prog_model (
  input  wire clk,
  output reg  supply = 1'b1,
  output reg  serial_in_pin  = 1'b0,
  output reg  strobe = 1'b0,
  output reg  commit = 1'b0
);
  // ==========
  // frame sender; strobe stands still between frames
  // tail bit first, clear bit last
  task clock_bits(input [15:0] f, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      serial_in_pin <= f[i];
      repeat (4) @(posedge clk);
      strobe <= 1'b1;
      repeat (4) @(posedge clk);
      strobe <= 1'b0;
    end
    // released data line falls to its pull-down
    serial_in_pin <= 1'b0;
  endtask
  task send(input [15:0] f, input integer n);
    clock_bits(f, n);
    commit <= 1'b1;
    repeat (8) @(posedge clk);
    commit <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // tep_prog_model

// File: tb/tep_top_asserts.sv
// checker: apb answer timing and trim decode relations
// assumes binding into tep_top, one clock domain
`timescale 1ns/1ns
module tep_top_asserts (
  input wire        CLOCK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire [8:0]  BALANCE_CAP_CODE,
  input wire [13:0] BALANCE_CAP_FF,
  input wire [5:0]  TRIM_CAP_CODE,
  input wire [10:0] TRIM_CAP_FF,
  input wire [3:0]  FILTER_CORNER_CODE,
  input wire [8:0]  FILTER_SEL,
  input wire [4:0]  DC_SHIFT_TRIM,
  input wire [5:0]  DC_SHIFT_STEPS,
  input wire [7:0]  GAIN_FINE_TRIM,
  input wire [8:0]  GAIN_FINE_STEPS
);
  // ==========
  // apb answer
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  a_ready_setup:
    assert property (PSEL && !PENABLE && !PREADY |=> PREADY) else $error("no answer after setup");
  a_ready_once:
    assert property (PREADY |=> !PREADY) else $error("answer held too long");
  a_ready_cause:
    assert property (PREADY |-> $past(PSEL) && !$past(PENABLE)) else $error("answer without setup");
  a_err_ready:
    assert property (PSLVERR |-> PREADY && PSEL) else $error("error outside answer");
  // ==========
  // trim decode, a level derived from its code
  a_bal_ff:
    assert property (BALANCE_CAP_FF == BALANCE_CAP_CODE * 14'h013) else $error("balance cap value");
  a_trim_ff:
    assert property (TRIM_CAP_FF == TRIM_CAP_CODE * 11'h013) else $error("trim cap value");
  a_filter_hot:
    assert property (FILTER_SEL == ((FILTER_CORNER_CODE < 4'h9) ? (9'h001 << FILTER_CORNER_CODE) : 9'h000))
      else $error("filter select");
  a_dc_steps:
    assert property (DC_SHIFT_STEPS == {1'b0, DC_SHIFT_TRIM} - 6'h10) else $error("dc shift steps");
  a_gain_steps:
    assert property (GAIN_FINE_STEPS == {1'b0, GAIN_FINE_TRIM} - 9'h080) else $error("gain steps");
endmodule // tep_top_asserts

// File: tb/tep_top_bench.sv
// bench: apb master, programmer traffic and a map model
// assumes APPLY_DIV shortened to 4; fifo of 16 frames
`timescale 1ns/1ns
`include "tep_consts.vh"
module tep_top_bench;
  localparam AD = 4;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg  [7:0]  padr = 8'h00;
  reg  [31:0] pwd = 32'h0;
  wire        prdy, perr, sup, sdi, stb, cmt, base, amp;
  wire [31:0] prd;
  wire [8:0]  bal, fsel, gst;
  wire [13:0] balf;
  wire [5:0]  trim, dst;
  wire [10:0] trimf;
  wire [9:0]  fb;
  wire [3:0]  filt, refv;
  wire [4:0]  dc;
  wire [7:0]  gain;
  wire [2:0]  bias, osc;
  reg  [9:0]  w [0:9];
  reg  [9:0]  c;
  reg  [31:0] r;
  reg         e;
  integer     errors = 0, n_tests = 0, seed = 32'h03ef, k;
  always #10 clk = ~clk;
  tep_prog_model u_prog (.clk(clk), .supply(sup), .serial_in_pin(sdi), .strobe(stb), .commit(cmt));
  tep_top #(.APPLY_DIV(AD)) u_dut (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PREADY(prdy), .PRDATA(prd), .PSLVERR(perr),
    .PROG_SUPPLY_PIN(sup), .SERIAL_IN_PIN(sdi), .SERIAL_STROBE_PIN(stb), .COMMIT_PIN(cmt),
    .BALANCE_CAP_CODE(bal), .BALANCE_CAP_FF(balf), .TRIM_CAP_CODE(trim), .TRIM_CAP_FF(trimf),
    .FEEDBACK_CAP_CODE(fb), .FILTER_CORNER_CODE(filt), .FILTER_SEL(fsel), .OUTPUT_BASE_SEL(base),
    .DC_SHIFT_TRIM(dc), .DC_SHIFT_STEPS(dst), .GAIN_FINE_TRIM(gain), .GAIN_FINE_STEPS(gst),
    .AMP_RANGE_SEL(amp), .REF_VOLT_TRIM(refv), .BIAS_CURRENT_TRIM(bias), .OSC_TRIM(osc));
  // ==========
  // shared tasks
  task chk(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    integer i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) begin
      i = i + 1;
      if (i > 20) begin
        errors = errors + 1;
        conclude;
      end
      @(posedge clk);
    end
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task st(input [31:0] m, input [31:0] x);
    apb(1'b0, `TEP_ADDR_STATUS, 32'h0);
    chk(r & m, x);
  endtask
  task frame(input cn, input [3:0] ix, input [9:0] d);
    reg [15:0] f;
    integer    j;
    f = {cn, d, ix, 1'b0};
    f[0] = $random(seed);
    u_prog.send(f, 16);
    repeat (AD + 2) @(posedge clk);
    apb(1'b0, `TEP_ADDR_SHIFT, 32'h0);
    chk(r, f);
    if (sup !== 1'b1)
      ;
    else if (!cn)
      for (j = 0; j < 10; j = j + 1) w[j] = 10'h000;
    else if (ix < 4'ha)
      w[ix] = d;
  endtask
  task dchk;
    reg [8:0] b9;
    reg [5:0] t6;
    reg [4:0] d5;
    reg [7:0] g8;
    reg [2:0] o3;
    integer   j;
    b9 = {w[5][6:0], w[4][9:8]};
    t6 = {<<{w[4][7:2]}};
    d5 = {<<{w[8][0], w[7][9:6]}};
    g8 = {<<{w[8][8:1]}};
    o3 = {<<{w[9][2:0]}};
    chk(bal, b9);
    chk(balf, b9 * 32'h13);
    chk(trim, t6);
    chk(trimf, t6 * 32'h13);
    chk(filt, w[7][4:1]);
    chk(fsel, (w[7][4:1] < 4'h9) ? (32'h1 << w[7][4:1]) : 32'h0);
    chk(base, w[7][5]);
    chk(dc, d5);
    chk(dst, ({27'h0, d5} - 32'h10) & 32'h3f);
    chk(gain, g8);
    chk(gst, ({24'h0, g8} - 32'h80) & 32'h1ff);
    chk({amp, fb}, {w[6][8], w[6][6:0], w[5][9:7]});
    chk({refv, bias, osc}, {w[9][6:3], w[9][9:7], o3});
    for (j = 0; j < 10; j = j + 1) begin
      apb(1'b0, `TEP_ADDR_MAP_BASE + 4 * j, 32'h0);
      chk(r, w[j]);
    end
  endtask
  // ==========
  // main sequence
  initial begin
    for (k = 0; k < 10; k = k + 1) w[k] = 10'h000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    dchk;
    st(32'h1fff, 32'h2);
    $display("test reset done");
    c = $random(seed);
    frame(1'b0, c[3:0], $random(seed));
    for (k = 4; k < 10; k = k + 1) begin
      c = $random(seed);
      if (k == 7) c[4] = 1'b0;
      frame(1'b1, k, c);
    end
    dchk;
    $display("test write done");
    for (k = 0; k < 9; k = k + 1) begin
      c = $random(seed);
      c[4:1] = k;
      // only the changed word is sent
      frame(1'b1, 4'h7, c);
      dchk;
    end
    $display("test filter done");
    frame(1'b1, 4'hc, $random(seed));
    st(32'h10, 32'h10);
    apb(1'b1, `TEP_ADDR_STATUS, 32'h10);
    st(32'h10, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 8'h50, 32'h3ff);
    chk(e, 1'b0);
    u_prog.send(16'hffff, 8);
    st(32'h1f80, 32'h80);
    u_prog.clock_bits(16'h0000, 5);
    st(32'h1f00, 32'h500);
    apb(1'b1, `TEP_ADDR_CTRL, 32'h2);
    st(32'h1f00, 32'h0);
    u_prog.supply <= 1'b0;
    frame(1'b1, 4'h5, $random(seed));
    u_prog.supply <= 1'b1;
    st(32'h40, 32'h40);
    dchk;
    $display("test refuse done");
    apb(1'b1, `TEP_ADDR_CTRL, 32'h1);
    for (k = 0; k < 17; k = k + 1) begin
      c = $random(seed);
      if (k == 15) w[4] = c;
      u_prog.send({1'b1, c, 4'h4, 1'b0}, 16);
    end
    st(32'he, 32'hc);
    apb(1'b1, `TEP_ADDR_CTRL, 32'h0);
    repeat (16 * AD + 20) @(posedge clk);
    st(32'h6, 32'h2);
    dchk;
    $display("test fifo done");
    conclude;
  end
endmodule // tep_top_bench
bind tep_top tep_top_asserts u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .BALANCE_CAP_CODE(BALANCE_CAP_CODE),
  .BALANCE_CAP_FF(BALANCE_CAP_FF), .TRIM_CAP_CODE(TRIM_CAP_CODE), .TRIM_CAP_FF(TRIM_CAP_FF),
  .FILTER_CORNER_CODE(FILTER_CORNER_CODE), .FILTER_SEL(FILTER_SEL), .DC_SHIFT_TRIM(DC_SHIFT_TRIM),
  .DC_SHIFT_STEPS(DC_SHIFT_STEPS), .GAIN_FINE_TRIM(GAIN_FINE_TRIM), .GAIN_FINE_STEPS(GAIN_FINE_STEPS));
